// ---- logic/vec_ack_host.sv ----
// host end: acknowledge sequencing and handler address forming
// assumes instruction boundary is signalled by the core
`timescale 1ns/100ps
module vec_ack_host (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rstn_i,
    vec_ack_if.host                    bus,
    input  wire vec_ack_pkg::int_mode_t mode_i,
    input  wire logic                  small_system_select_i,
    input  wire logic                  bus_status_bit0_n_i,
    input  wire logic                  bus_status_bit1_n_i,
    input  wire logic                  bus_status_bit2_n_i,
    input  wire logic                  instr_done_i,
    input  wire logic [7:0]            page_i,
    output logic                       branch_o,
    output logic [15:0]                handler_addr_o,
    output logic                       bad_opcode_o
);
    // ===========================================
    // sequencer
    typedef enum logic [1:0] {IDLE, ACK, READ, HOLD} state_t;
    state_t      state_reg;
    logic        host_ack_strobe_n;
    logic [2:0]  status;
    logic        status_ack;

    assign status = {bus_status_bit2_n_i, bus_status_bit1_n_i,
                     bus_status_bit0_n_i};
    assign status_ack = (status == vec_ack_pkg::STATUS_INT_ACK);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= IDLE;
        end else begin
            case (state_reg)
                IDLE: begin
                    if (!bus.irq_request_n && instr_done_i
                        && mode_i != vec_ack_pkg::FIXED_ADDRESS_MODE) begin
                        state_reg <= ACK;
                    end else if (!bus.irq_request_n && instr_done_i) begin
                        state_reg <= HOLD;
                    end
                end
                HOLD: begin
                    // one branch per request until the cause is cleared
                    if (bus.irq_request_n) begin
                        state_reg <= IDLE;
                    end
                end
                ACK: begin
                    state_reg <= READ;
                end
                READ: begin
                    state_reg <= IDLE;
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    assign host_ack_strobe_n = small_system_select_i ?
                               !(state_reg == ACK || state_reg == READ) :
                               !status_ack;
    assign bus.irq_acknowledge_n = host_ack_strobe_n;
    assign bus.data_host_o = 8'h00;
    assign bus.data_host_oe = 1'b0;

    // ===========================================
    // branch
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            branch_o <= 1'b0;
            handler_addr_o <= 16'h0000;
            bad_opcode_o <= 1'b0;
        end else begin
            branch_o <= 1'b0;
            bad_opcode_o <= 1'b0;
            if (state_reg == IDLE && !bus.irq_request_n && instr_done_i
                && mode_i == vec_ack_pkg::FIXED_ADDRESS_MODE) begin
                branch_o <= 1'b1;
                handler_addr_o <= vec_ack_pkg::FIXED_ADDR;
            end else if (state_reg == READ) begin
                branch_o <= 1'b1;
                if (mode_i == vec_ack_pkg::PERIPHERAL_VECTORED_MODE) begin
                    handler_addr_o <= {page_i, bus.data_bus[7:1],
                                       1'b0};
                end else begin
                    handler_addr_o <= vec_ack_pkg::RESTART_ADDR;
                    bad_opcode_o <= (bus.data_bus !=
                                     vec_ack_pkg::RESTART_OPCODE);
                end
            end
        end
    end
endmodule

// ---- include/vec_ack_pkg.sv ----
// package for the vectored interrupt acknowledge port
// assumes a single 125 MHz clock shared by both ends
package vec_ack_pkg;
    localparam int          DATA_W            = 8;
    localparam int          ADDR_W            = 16;
    localparam logic [7:0]  VECTOR_LSB_MASK   = 8'hfe;
    localparam logic [7:0]  RESTART_OPCODE    = 8'he7;
    localparam logic [15:0] RESTART_ADDR      = 16'h0020;
    localparam logic [15:0] FIXED_ADDR        = 16'h0038;
    localparam logic [7:0]  PAGE_RESET        = 8'h00;
    localparam logic [7:0]  VECTOR_RESET      = 8'h00;
    // bus status codes, active-low pins s2 s1 s0
    localparam logic [2:0]  STATUS_INT_ACK    = 3'h0;
    localparam logic [2:0]  STATUS_IO_READ    = 3'h1;
    localparam logic [2:0]  STATUS_IO_WRITE   = 3'h2;
    localparam logic [2:0]  STATUS_HALT       = 3'h3;
    localparam logic [2:0]  STATUS_CODE_FETCH = 3'h4;
    localparam logic [2:0]  STATUS_MEM_READ   = 3'h5;
    localparam logic [2:0]  STATUS_MEM_WRITE  = 3'h6;
    localparam logic [2:0]  STATUS_PASSIVE    = 3'h7;
    typedef enum logic [1:0] {
        EXTERNAL_VECTORED_MODE,
        FIXED_ADDRESS_MODE,
        PERIPHERAL_VECTORED_MODE
    } int_mode_t;
endpackage

// ---- include/vec_ack_if.sv ----
// interface joining the interrupt port and the host
// assumes both ends run on clk_sys_i
`timescale 1ns/100ps
interface vec_ack_if;
    logic       irq_request_n;
    logic       irq_acknowledge_n;
    logic [7:0] data_dev_o;
    logic       data_dev_oe;
    logic [7:0] data_host_o;
    logic       data_host_oe;
    logic [7:0] data_bus;
    assign data_bus = data_dev_oe ? data_dev_o :
                      data_host_oe ? data_host_o : 8'hff;
    modport device (
        output irq_request_n,
        input  irq_acknowledge_n,
        output data_dev_o,
        output data_dev_oe,
        input  data_bus
    );
    modport host (
        input  irq_request_n,
        output irq_acknowledge_n,
        output data_host_o,
        output data_host_oe,
        input  data_bus
    );
endinterface

// ---- logic/vec_ack_device.sv ----
// device end of the chained-vector interrupt port
// assumes pending causes and clear command come from the uart core
`timescale 1ns/100ps
module vec_ack_device (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    vec_ack_if.device       bus,
    input  wire logic       pending_i,
    input  wire logic       chain_enable_in_i,
    output logic            chain_enable_out_o,
    input  wire logic       vector_we_i,
    input  wire logic [7:0] vector_wdata_i,
    input  wire logic       clear_in_service_command_i,
    output logic            in_service_o
);
    // ===========================================
    // vector register
    logic [7:0] vector_register_reg;
    logic       ack_prev_reg;
    logic       in_service_reg;
    logic       ack_start;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vector_register_reg <= vec_ack_pkg::VECTOR_RESET;
        end else if (vector_we_i) begin
            vector_register_reg <= vector_wdata_i;
        end
    end

    // ===========================================
    // acknowledge detection
    assign ack_start = !bus.irq_acknowledge_n && ack_prev_reg;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_prev_reg <= 1'b1;
        end else begin
            ack_prev_reg <= bus.irq_acknowledge_n;
        end
    end

    // ===========================================
    // in service tracking
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_service_reg <= 1'b0;
        end else if (ack_start && !bus.irq_request_n) begin
            in_service_reg <= 1'b1;
        end else if (clear_in_service_command_i) begin
            in_service_reg <= 1'b0;
        end
    end

    // ===========================================
    // request and chain
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.irq_request_n <= 1'b1;
        end else begin
            bus.irq_request_n <= !(pending_i && chain_enable_in_i
                                   && !in_service_reg);
        end
    end

    assign chain_enable_out_o = chain_enable_in_i && bus.irq_request_n
                                && !in_service_reg;

    // ===========================================
    // data bus drive
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.data_dev_o <= vec_ack_pkg::VECTOR_RESET;
        end else begin
            bus.data_dev_o <= vector_register_reg
                              & vec_ack_pkg::VECTOR_LSB_MASK;
        end
    end

    assign bus.data_dev_oe = !bus.irq_acknowledge_n && !ack_prev_reg
                             && in_service_reg;
    assign in_service_o = in_service_reg;
endmodule

// ---- testbench/vec_ack_assertions.sv ----
// checker for the interrupt acknowledge interface
// assumes one clock and the interface signals as plain inputs
`timescale 1ns/100ps
module vec_ack_assertions (
    input wire logic       clk_sys_i,
    input wire logic       rstn_i,
    input wire logic       irq_request_n,
    input wire logic       irq_acknowledge_n,
    input wire logic [7:0] data_dev_o,
    input wire logic       data_dev_oe,
    input wire logic [7:0] data_bus
);
    // ==========================================================
    // sequences
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence ack_start;
        $fell(irq_acknowledge_n);
    endsequence
    sequence vec_out;
        data_dev_oe ##1 data_dev_oe;
    endsequence
    // ==========================================================
    // properties
    oe_in_ack_a: assert property (data_dev_oe |-> !irq_acknowledge_n)
        else $error("vector driven outside acknowledge");
    vec_lsb_a: assert property (data_dev_oe |-> !data_dev_o[0])
        else $error("vector lsb not zero");
    bus_vector_a: assert property (data_dev_oe |-> data_bus == data_dev_o)
        else $error("bus does not carry vector");
    ack_drive_a: assert property (ack_start |=> data_dev_oe)
        else $error("no vector after acknowledge");
    vec_hold_a: assert property (vec_out |-> $stable(data_dev_o))
        else $error("vector changed while driven");
    ack_req_a: assert property (ack_start |-> $past(!irq_request_n))
        else $error("acknowledge without request");
    req_drop_a: assert property ($rose(irq_acknowledge_n)
        |-> ##[0:3] irq_request_n)
        else $error("request kept after service");
endmodule

// ---- testbench/test_vectored_interrupt_ack_port.sv ----
// bench joining device and host ends through the interface
// assumes the package and interface are compiled first
`timescale 1ns/100ps
module test_vectored_interrupt_ack_port;
    logic                   clk_sys_i = 0;
    logic                   rstn_i = 0;
    logic                   pend = 0, cin = 1, vwe = 0, clr = 0, sel = 1;
    logic                   idone = 1, branch, cout, bad;
    logic [7:0]             vdat = 8'h00, page = 8'h00;
    logic [2:0]             st = 3'h7;
    logic [15:0]            haddr, exq[$];
    vec_ack_pkg::int_mode_t mode = vec_ack_pkg::PERIPHERAL_VECTORED_MODE;
    int                     n_mismatch = 0, total_checks = 0, cyc = 0;
    vec_ack_if bus ();
    vec_ack_device i_vec_ack_device (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .bus(bus), .pending_i(pend), .chain_enable_in_i(cin),
        .chain_enable_out_o(cout), .vector_we_i(vwe), .vector_wdata_i(vdat),
        .clear_in_service_command_i(clr), .in_service_o());
    vec_ack_host i_vec_ack_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .bus(bus), .mode_i(mode), .small_system_select_i(sel),
        .bus_status_bit0_n_i(st[0]), .bus_status_bit1_n_i(st[1]),
        .bus_status_bit2_n_i(st[2]), .instr_done_i(idone), .page_i(page),
        .branch_o(branch), .handler_addr_o(haddr), .bad_opcode_o(bad));
    vec_ack_assertions i_vec_ack_assertions (.clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i), .irq_request_n(bus.irq_request_n),
        .irq_acknowledge_n(bus.irq_acknowledge_n),
        .data_dev_o(bus.data_dev_o), .data_dev_oe(bus.data_dev_oe),
        .data_bus(bus.data_bus));
    // ==========================================================
    // clock, checks and closing
    initial forever #4 clk_sys_i = ~clk_sys_i;
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 5000) begin
            n_mismatch++;
            close_out();
        end
        if (branch === 1'b1) begin
            if (exq.size() == 0) chk("branch", 16'h0000, 16'h0001);
            else chk("handler", exq.pop_front(), haddr);
        end
        if (branch === 1'b1
            && mode == vec_ack_pkg::EXTERNAL_VECTORED_MODE)
            chk("bad_opcode", 16'h0001, {15'h0000, bad});
        if (mode == vec_ack_pkg::FIXED_ADDRESS_MODE && pend)
            chk("ack", 16'h0001, {15'h0000, bus.irq_acknowledge_n});
    end
    // ==========================================================
    // one serviced interrupt
    task svc(input vec_ack_pkg::int_mode_t m, input logic s, input logic [7:0] v);
        logic [7:0] pg;
        int         k;
        pg = 8'($urandom);
        @(posedge clk_sys_i) {vwe, vdat, mode, page, sel} <= {1'b1, v, m, pg, s};
        @(posedge clk_sys_i) {vwe, pend} <= 2'b01;
        exq.push_back(m == vec_ack_pkg::FIXED_ADDRESS_MODE ?
            vec_ack_pkg::FIXED_ADDR :
            m == vec_ack_pkg::EXTERNAL_VECTORED_MODE ?
            vec_ack_pkg::RESTART_ADDR : {pg, v[7:1], 1'b0});
        if (!s) begin
            repeat (2) @(posedge clk_sys_i);
            st <= 3'h0;
        end
        k = 0;
        while (branch !== 1'b1 && k < 40) begin
            @(posedge clk_sys_i);
            k++;
        end
        @(posedge clk_sys_i) {pend, st} <= 4'h7;
        repeat (2) @(posedge clk_sys_i);
        if (m != vec_ack_pkg::FIXED_ADDRESS_MODE)
            chk("chain_out", 16'h0000, {15'h0000, cout});
        @(posedge clk_sys_i) clr <= 1;
        @(posedge clk_sys_i) clr <= 0;
        repeat (2) @(posedge clk_sys_i);
        chk("chain_out", 16'h0001, {15'h0000, cout});
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(46655));
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1;
        for (int i = 0; i < 6; i++)
            svc(vec_ack_pkg::PERIPHERAL_VECTORED_MODE, 1'b1, 8'($urandom));
        @(posedge clk_sys_i) {cin, pend} <= 2'b01;
        repeat (5) @(posedge clk_sys_i);
        chk("request", 16'h0001, {15'h0000, bus.irq_request_n});
        chk("chain_out", 16'h0000, {15'h0000, cout});
        @(posedge clk_sys_i) {sel, st, cin, pend} <= {1'b0, 3'h1, 2'b10};
        for (int c = 1; c < 8; c++) begin
            @(posedge clk_sys_i) st <= 3'(c);
            repeat (2) @(posedge clk_sys_i);
            chk("status_ack", 16'h0001, {15'h0000, bus.irq_acknowledge_n});
        end
        svc(vec_ack_pkg::PERIPHERAL_VECTORED_MODE, 1'b0, 8'($urandom));
        svc(vec_ack_pkg::EXTERNAL_VECTORED_MODE, 1'b1,
            vec_ack_pkg::RESTART_OPCODE);
        svc(vec_ack_pkg::FIXED_ADDRESS_MODE, 1'b1, 8'h5a);
        repeat (4) @(posedge clk_sys_i);
        chk("queue", 16'h0000, 16'(exq.size()));
        close_out();
    end
endmodule
